// [logic/audio_ctrl_pkg.sv]
// Constants, tables and types for the audio control serial register block
// Notes on behaviour
// [RULE1] Controller leaves bus idle at least 4.7 us between stop and start; the bench controller model waits 2 * HALF_CYC cycles (128 ns) after stop.
// [RULE2] Controller holds start at least 4.0 us before first clock; the bench controller model holds it HALF_CYC cycles (64 ns).
// [RULE3] Clock low at least 4.7 us, high at least 4.0 us, max 100 kHz; the bench controller model holds low and high HALF_CYC cycles (64 ns) each.
// [RULE4] Write is start, address, ack, index, ack, data, ack, stop.
// [RULE5] Address byte bit 0 is direction; only writes (low) are answered.
// [RULE6] Device address is 1000000 plus strap bit; strap high sets it.
// [RULE7] Index 0..5 selects volumes, enhancer, bass, treble, gain control.
// [RULE8] Further data bytes go to successively higher indexes.
// [RULE9] Index advance never wraps from 5 to 0; extra bytes are dropped.
// [RULE10] Volume byte is one attenuation code; all ones 0 dB, zero muted.
// [RULE11] Volume code maps through a table from 0 dB to -84 dB, then mute.
// [RULE12] Register 2: upper nibble process level, lower nibble contour level.
// [RULE13] Registers 3 and 4: bit 7 enhancer or mute, low seven bits level.
// [RULE14] Register 5: gain control, surround, stereo, mono, loop enable bits.
// [RULE15] Register 5 bits 2..0 give surround effect level.
// [RULE16] Controller should mute before changing enhancer or surround settings.
// [RULE17] Bytes after a data byte are data, never a new index.
// [RULE18] Seven-bit tone codes map through a table from -15 dB to +15 dB.
// [RULE19] Surround code 0..7 maps to 3..10 dB in 1 dB steps.
// [RULE20] Ack matching address, index and data; write lands on data ack.
// [RULE21] Start mid-transfer restarts addressing; stop returns to idle.
package audio_ctrl_pkg;

   // ***********************************************
   // Clock and bus timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_BUF_NS = 4700;
   localparam int T_HD_STA_NS = 4000;
   localparam int T_LOW_NS = 4700;
   localparam int T_HIGH_NS = 4000;
   localparam int T_BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_HD_STA_CYC =
      (T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ***********************************************
   // Address, register map and field layout
   // ***********************************************
   localparam logic [5:0] DEV_ADDR_HIGH = 6'h20;
   localparam logic [7:0] IDX_LEFT_VOLUME = 8'h00;
   localparam logic [7:0] IDX_RIGHT_VOLUME = 8'h01;
   localparam logic [7:0] IDX_ENHANCER_LEVELS = 8'h02;
   localparam logic [7:0] IDX_ENHANCER_ENABLE_BASS = 8'h03;
   localparam logic [7:0] IDX_MUTE_TREBLE = 8'h04;
   localparam logic [7:0] IDX_GAIN_CTRL_SURROUND = 8'h05;
   localparam logic [7:0] IDX_LAST = 8'h05;
   localparam logic [7:0] IDX_SATURATE = 8'hFF;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int BIT_ENABLE = 7;
   localparam int BIT_SURROUND_ON = 6;
   localparam int BIT_SURROUND_STEREO = 5;
   localparam int BIT_SURROUND_MONO = 4;
   localparam int BIT_LOOP = 3;
   localparam logic [3:0] ACK_BIT_CNT = 4'h8;
   localparam logic [3:0] ACK_END_CNT = 4'h9;

   // ***********************************************
   // Decode tables
   // ***********************************************
   localparam logic [6:0] ATTEN_MUTED = 7'h7F;
   localparam int VOL_ONE_DB_LAST = 20;
   localparam int VOL_ENTRIES = 53;
   localparam logic [7:0] VOL_CODES [0:52] = '{
      8'hFF, 8'hEA, 8'hDF, 8'hD6, 8'hCF, 8'hC8, 8'hC2, 8'hB9, 8'hB8, 8'hB3,
      8'hAE, 8'hAA, 8'hA6, 8'hA2, 8'h9E, 8'h9A, 8'h96, 8'h93, 8'h90, 8'h8C,
      8'h89, 8'h83, 8'h7D, 8'h78, 8'h72, 8'h6D, 8'h68, 8'h64, 8'h5F, 8'h5B,
      8'h57, 8'h52, 8'h4F, 8'h4B, 8'h47, 8'h42, 8'h40, 8'h3D, 8'h3A, 8'h37,
      8'h34, 8'h32, 8'h2F, 8'h2D, 8'h2A, 8'h28, 8'h26, 8'h24, 8'h22, 8'h20,
      8'h1E, 8'h1D, 8'h1B};
   localparam int TONE_ENTRIES = 17;
   localparam logic [6:0] TONE_CODES [0:16] = '{
      7'h3F, 7'h36, 7'h32, 7'h2F, 7'h2D, 7'h2B, 7'h29, 7'h26, 7'h20,
      7'h1A, 7'h17, 7'h15, 7'h13, 7'h11, 7'h0E, 7'h0A, 7'h00};
   localparam logic signed [4:0] TONE_GAINS [0:16] = '{
      5'sd15, 5'sd14, 5'sd12, 5'sd10, 5'sd8, 5'sd6, 5'sd4, 5'sd2, 5'sd0,
      -5'sd2, -5'sd4, -5'sd6, -5'sd8, -5'sd10, -5'sd12, -5'sd14, -5'sd15};
   localparam logic [3:0] SURROUND_BASE_DB = 4'h3;

   // Receiver states, Gray coded along idle, address, index, data
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_INDEX = 3'b011,
      ST_DATA = 3'b010,
      ST_IGNORE = 3'b110
   } rx_state_t;

endpackage

// [logic/pin_sync.sv]
// Two-flop pin synchroniser with edge detection
`timescale 1ns/1ns
module pin_sync #(
   parameter logic IDLE_LEVEL = 1'b1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_reg;
   logic stable_reg;
   logic prev_reg;

   // First flop feeds only the second; edges come from later stages
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_reg <= IDLE_LEVEL;
         stable_reg <= IDLE_LEVEL;
         prev_reg <= IDLE_LEVEL;
      end else begin
         meta_reg <= pin_in;
         stable_reg <= meta_reg;
         prev_reg <= stable_reg;
      end
   end

   assign level = stable_reg;
   assign rise = stable_reg & ~prev_reg;
   assign fall = ~stable_reg & prev_reg;

endmodule

// [logic/audio_control_i2c_regs.sv]
// Write-only two-wire serial slave holding six audio control registers
`timescale 1ns/1ns
module audio_control_i2c_regs (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic chip_strap,
   output logic [7:0] left_volume,
   output logic [7:0] right_volume,
   output logic [7:0] enhancer_levels,
   output logic [7:0] enhancer_enable_bass,
   output logic [7:0] mute_treble,
   output logic [7:0] gain_ctrl_surround,
   output logic [3:0] enhancer_process,
   output logic [3:0] enhancer_contour,
   output logic enhancer_on,
   output logic [6:0] bass_level,
   output logic mute_on,
   output logic [6:0] treble_level,
   output logic agc_on,
   output logic surround_on,
   output logic surround_stereo,
   output logic surround_mono,
   output logic loop_on,
   output logic [2:0] surround_level,
   output logic [6:0] left_atten_db,
   output logic [6:0] right_atten_db,
   output logic signed [4:0] bass_gain_db,
   output logic signed [4:0] treble_gain_db,
   output logic [3:0] surround_gain_db
);

   // ***********************************************
   // Decode functions
   // ***********************************************

   // Volume code to attenuation in dB, muted code below the bottom entry
   function automatic logic [6:0] vol_to_atten(input logic [7:0] code);
      int i;
      logic [6:0] atten;
      atten = audio_ctrl_pkg::ATTEN_MUTED;
      for (i = audio_ctrl_pkg::VOL_ENTRIES - 1; i >= 0; i--) begin
         if (code >= audio_ctrl_pkg::VOL_CODES[i]) begin
            if (i <= audio_ctrl_pkg::VOL_ONE_DB_LAST) begin
               atten = 7'(i);
            end else begin
               atten = 7'(2 * i - audio_ctrl_pkg::VOL_ONE_DB_LAST);
            end
         end
      end
      return atten;
   endfunction

   // Tone code to signed gain, nearest table entry at or below the code
   function automatic logic signed [4:0] tone_to_gain(input logic [6:0] code);
      int i;
      logic signed [4:0] gain;
      gain = audio_ctrl_pkg::TONE_GAINS[audio_ctrl_pkg::TONE_ENTRIES - 1];
      for (i = audio_ctrl_pkg::TONE_ENTRIES - 1; i >= 0; i--) begin
         if (code >= audio_ctrl_pkg::TONE_CODES[i]) begin
            gain = audio_ctrl_pkg::TONE_GAINS[i];
         end
      end
      return gain;
   endfunction

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic scl_level;
   logic scl_rise;
   logic scl_fall;
   logic sda_level;
   logic sda_rise;
   logic sda_fall;
   logic strap_level;

   pin_sync scl_sync (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(scl_in),
      .level(scl_level), .rise(scl_rise), .fall(scl_fall)
   );
   pin_sync sda_sync (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(sda_in),
      .level(sda_level), .rise(sda_rise), .fall(sda_fall)
   );
   pin_sync #(.IDLE_LEVEL(1'b0)) strap_sync (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(chip_strap),
      .level(strap_level), .rise(), .fall()
   );

   // ***********************************************
   // Receiver
   // ***********************************************
   audio_ctrl_pkg::rx_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] index_reg;
   logic ack_oe_reg;
   logic [7:0] regs_reg [0:5];
   logic start_cond;
   logic stop_cond;
   logic addr_match;
   logic accept;
   logic ack_begin;
   logic ack_commit;
   logic ack_end;

   assign start_cond = sda_fall & scl_level;
   assign stop_cond = sda_rise & scl_level;
   assign ack_begin = scl_fall && bit_cnt_reg == audio_ctrl_pkg::ACK_BIT_CNT;
   assign ack_commit = scl_rise && bit_cnt_reg == audio_ctrl_pkg::ACK_END_CNT
      && ack_oe_reg;
   assign ack_end = scl_fall && bit_cnt_reg == audio_ctrl_pkg::ACK_END_CNT;

   // [RULE5] [RULE6] write-direction address match
   assign addr_match = shift_reg[7:1] ==
      {audio_ctrl_pkg::DEV_ADDR_HIGH, strap_level} && !shift_reg[0];
   assign accept = (state_reg == audio_ctrl_pkg::ST_ADDR) ? addr_match :
      (state_reg == audio_ctrl_pkg::ST_INDEX ||
       state_reg == audio_ctrl_pkg::ST_DATA);

   // [RULE4] eight data bits then one ack bit
   always_ff @(posedge sys_clk) begin
      if (sys_rst || start_cond || stop_cond) begin
         bit_cnt_reg <= 4'h0;
      end else if (ack_end) begin
         bit_cnt_reg <= 4'h0;
      end else if (ack_begin) begin
         bit_cnt_reg <= audio_ctrl_pkg::ACK_END_CNT;
      end else if (scl_rise && bit_cnt_reg < audio_ctrl_pkg::ACK_BIT_CNT) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // Serial shift, most significant bit first
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         shift_reg <= 8'h00;
      end else if (scl_rise && bit_cnt_reg < audio_ctrl_pkg::ACK_BIT_CNT) begin
         shift_reg <= {shift_reg[6:0], sda_level};
      end
   end

   // [RULE21] start restarts addressing, stop returns to idle
   always_ff @(posedge sys_clk) begin
      if (sys_rst || stop_cond) begin
         state_reg <= audio_ctrl_pkg::ST_IDLE;
      end else if (start_cond) begin
         state_reg <= audio_ctrl_pkg::ST_ADDR;
      end else if (ack_end) begin
         case (state_reg)
            audio_ctrl_pkg::ST_ADDR: begin
               state_reg <= ack_oe_reg ? audio_ctrl_pkg::ST_INDEX :
                  audio_ctrl_pkg::ST_IGNORE;
            end
            audio_ctrl_pkg::ST_INDEX: begin
               state_reg <= audio_ctrl_pkg::ST_DATA;
            end
            // [RULE17] data stays data
            audio_ctrl_pkg::ST_DATA: begin
               state_reg <= audio_ctrl_pkg::ST_DATA;
            end
            default: begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // [RULE20] pull data low through the ack bit only when accepted
   always_ff @(posedge sys_clk) begin
      if (sys_rst || start_cond || stop_cond || ack_end) begin
         ack_oe_reg <= 1'b0;
      end else if (ack_begin) begin
         ack_oe_reg <= accept;
      end
   end

   // [RULE7] [RULE8] [RULE9] index load and saturating advance
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         index_reg <= 8'h00;
      end else if (ack_commit && state_reg == audio_ctrl_pkg::ST_INDEX) begin
         index_reg <= shift_reg;
      end else if (ack_commit && state_reg == audio_ctrl_pkg::ST_DATA &&
                   index_reg != audio_ctrl_pkg::IDX_SATURATE) begin
         index_reg <= index_reg + 8'h01;
      end
   end

   // [RULE20] register takes the byte on its ack clock
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int r = 0; r <= 5; r++) begin
            regs_reg[r] <= audio_ctrl_pkg::REG_RESET;
         end
      end else if (ack_commit && state_reg == audio_ctrl_pkg::ST_DATA &&
                   index_reg <= audio_ctrl_pkg::IDX_LAST) begin
         regs_reg[index_reg[2:0]] <= shift_reg;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = ack_oe_reg;

   // ***********************************************
   // Register outputs and field decode
   // ***********************************************
   assign left_volume = regs_reg[audio_ctrl_pkg::IDX_LEFT_VOLUME[2:0]];
   assign right_volume = regs_reg[audio_ctrl_pkg::IDX_RIGHT_VOLUME[2:0]];
   assign enhancer_levels = regs_reg[audio_ctrl_pkg::IDX_ENHANCER_LEVELS[2:0]];
   assign enhancer_enable_bass =
      regs_reg[audio_ctrl_pkg::IDX_ENHANCER_ENABLE_BASS[2:0]];
   assign mute_treble = regs_reg[audio_ctrl_pkg::IDX_MUTE_TREBLE[2:0]];
   assign gain_ctrl_surround =
      regs_reg[audio_ctrl_pkg::IDX_GAIN_CTRL_SURROUND[2:0]];

   // [RULE12] process and contour nibbles
   assign enhancer_process = enhancer_levels[7:4];
   assign enhancer_contour = enhancer_levels[3:0];
   // [RULE13] enable bits and tone levels
   assign enhancer_on = enhancer_enable_bass[audio_ctrl_pkg::BIT_ENABLE];
   assign bass_level = enhancer_enable_bass[6:0];
   assign mute_on = mute_treble[audio_ctrl_pkg::BIT_ENABLE];
   assign treble_level = mute_treble[6:0];
   // [RULE14] gain control and surround modes
   assign agc_on = gain_ctrl_surround[audio_ctrl_pkg::BIT_ENABLE];
   assign surround_on = gain_ctrl_surround[audio_ctrl_pkg::BIT_SURROUND_ON];
   assign surround_stereo =
      gain_ctrl_surround[audio_ctrl_pkg::BIT_SURROUND_STEREO];
   assign surround_mono = gain_ctrl_surround[audio_ctrl_pkg::BIT_SURROUND_MONO];
   assign loop_on = gain_ctrl_surround[audio_ctrl_pkg::BIT_LOOP];
   // [RULE15] surround effect level
   assign surround_level = gain_ctrl_surround[2:0];

   // [RULE10] [RULE11] [RULE18] [RULE19] gain lookups, one cycle behind
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         left_atten_db <= audio_ctrl_pkg::ATTEN_MUTED;
         right_atten_db <= audio_ctrl_pkg::ATTEN_MUTED;
         bass_gain_db <= -5'sd15;
         treble_gain_db <= -5'sd15;
         surround_gain_db <= audio_ctrl_pkg::SURROUND_BASE_DB;
      end else begin
         left_atten_db <= vol_to_atten(left_volume);
         right_atten_db <= vol_to_atten(right_volume);
         bass_gain_db <= tone_to_gain(bass_level);
         treble_gain_db <= tone_to_gain(treble_level);
         surround_gain_db <= {1'b0, surround_level} +
            audio_ctrl_pkg::SURROUND_BASE_DB;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_ADDR_ACK: assert property ( // [RULE6]
      ack_begin && state_reg == audio_ctrl_pkg::ST_ADDR && addr_match
      && !start_cond && !stop_cond |=> sda_oe [*1] ##1 sda_oe || ack_end)
      else $error("matching address not acknowledged");
   AST_NO_READ: assert property ( // [RULE5]
      ack_begin && state_reg == audio_ctrl_pkg::ST_ADDR && shift_reg[0]
      |=> !sda_oe)
      else $error("read request acknowledged");
   AST_INDEX_LOAD: assert property ( // [RULE7]
      ack_commit && state_reg == audio_ctrl_pkg::ST_INDEX
      |=> index_reg == $past(shift_reg))
      else $error("index not loaded");
   AST_INDEX_STEP: assert property ( // [RULE8]
      ack_commit && state_reg == audio_ctrl_pkg::ST_DATA && index_reg < 8'h05
      |=> index_reg == $past(index_reg) + 8'h01)
      else $error("index not advanced");
   AST_NO_WRAP: assert property ( // [RULE9]
      ack_commit && index_reg > audio_ctrl_pkg::IDX_LAST
      |=> $stable(left_volume) && $stable(gain_ctrl_surround))
      else $error("write past last register altered a register");
   AST_WRITE_LANDS: assert property ( // [RULE20]
      ack_commit && state_reg == audio_ctrl_pkg::ST_DATA && index_reg == 8'h00
      |=> left_volume == $past(shift_reg))
      else $error("data byte not stored");
   AST_DATA_STAYS: assert property ( // [RULE17]
      ack_end && state_reg == audio_ctrl_pkg::ST_DATA && !start_cond
      && !stop_cond |=> state_reg == audio_ctrl_pkg::ST_DATA)
      else $error("byte after data treated as index");
   AST_START_ABORT: assert property ( // [RULE21]
      start_cond && !stop_cond
      |=> state_reg == audio_ctrl_pkg::ST_ADDR && !sda_oe && bit_cnt_reg == 0)
      else $error("start did not restart addressing");
   AST_VOL_TOP: assert property ( // [RULE11]
      left_volume == 8'hFF ##1 left_volume == 8'hFF |-> left_atten_db == 7'h00)
      else $error("full volume code not 0 dB");
   AST_SURR_GAIN: assert property ( // [RULE19]
      ##1 surround_gain_db == {1'b0, $past(surround_level)} + 4'h3)
      else $error("surround gain wrong");

   COV_WRITE: cover property (
      ack_commit && state_reg == audio_ctrl_pkg::ST_DATA);
   COV_BURST: cover property (ack_commit && index_reg == 8'h05);
   COV_IGNORE: cover property (state_reg == audio_ctrl_pkg::ST_IGNORE);

endmodule

// [testbench/bus_controller_model.sv]
// Two-wire bus controller model that drives the serial clock and data lines
`timescale 1ns/1ns
module bus_controller_model #(
   parameter int HALF_CYC = 8
) (
   input wire logic sys_clk,
   input wire logic sda_wire,
   output logic scl_line,
   output logic sda_line
);
   // ***********************************************
   // Line idle levels and cycle helper
   // ***********************************************
   initial begin
      scl_line = 1'b1;
      sda_line = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic start_cond();
      scl_line <= 1'b0;
      tick(HALF_CYC / 2);
      sda_line <= 1'b1;
      tick(HALF_CYC / 2);
      scl_line <= 1'b1;
      tick(HALF_CYC);
      sda_line <= 1'b0;
      tick(HALF_CYC);
   endtask

   task automatic stop_cond();
      scl_line <= 1'b0;
      tick(HALF_CYC / 2);
      sda_line <= 1'b0;
      tick(HALF_CYC / 2);
      scl_line <= 1'b1;
      tick(HALF_CYC);
      sda_line <= 1'b1;
      tick(2 * HALF_CYC);
   endtask

   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         scl_line <= 1'b0;
         tick(HALF_CYC / 2);
         sda_line <= b[7 - i];
         tick(HALF_CYC / 2);
         scl_line <= 1'b1;
         tick(HALF_CYC);
      end
   endtask

   // byte, MSB first, then released ack bit
   task automatic send_byte(input logic [7:0] b, output logic ack);
      send_bits(b, 8);
      scl_line <= 1'b0;
      tick(HALF_CYC / 2);
      sda_line <= 1'b1;
      tick(HALF_CYC / 2);
      scl_line <= 1'b1;
      tick(HALF_CYC / 2);
      ack = ~sda_wire;
      tick(HALF_CYC / 2);
   endtask
endmodule

// [testbench/audio_control_i2c_regs_tb.sv]
// Self-checking bench for the audio control serial register block
`timescale 1ns/1ns
`define CHECK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp); \
      end \
   end
module audio_control_i2c_regs_tb;
   logic sys_clk, sys_rst, chip_strap, sda_out, sda_oe, scl_line, sda_line;
   logic [7:0] left_volume, right_volume, enhancer_levels;
   logic [7:0] enhancer_enable_bass, mute_treble, gain_ctrl_surround;
   logic [3:0] enhancer_process, enhancer_contour, surround_gain_db;
   logic enhancer_on, mute_on, agc_on, surround_on;
   logic surround_stereo, surround_mono, loop_on;
   logic [6:0] bass_level, treble_level, left_atten_db, right_atten_db;
   logic [2:0] surround_level;
   logic signed [4:0] bass_gain_db, treble_gain_db;
   wire logic sda_wire;
   int failures = 0;
   int n_checks = 0;
   logic [7:0] vc [8] = '{
      8'hFF, 8'hEA, 8'hC9, 8'h89, 8'h83, 8'h1B, 8'h1A, 8'h00};
   logic [6:0] va [8] = '{
      7'h00, 7'h01, 7'h05, 7'h14, 7'h16, 7'h54, 7'h7F, 7'h7F};
   logic [7:0] tc [4] = '{8'h7F, 8'h20, 8'h19, 8'h00};
   logic signed [4:0] tg [4] = '{5'sd15, 5'sd0, -5'sd4, -5'sd15};

   // Open-drain data line with pull-up
   assign sda_wire = sda_line & ~(sda_oe & ~sda_out);

   // Clock generator
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   audio_control_i2c_regs i_audio_control_i2c_regs (
      .sys_clk, .sys_rst, .scl_in(scl_line), .sda_in(sda_wire), .sda_out,
      .sda_oe, .chip_strap, .left_volume, .right_volume, .enhancer_levels,
      .enhancer_enable_bass, .mute_treble, .gain_ctrl_surround,
      .enhancer_process, .enhancer_contour, .enhancer_on, .bass_level,
      .mute_on, .treble_level, .agc_on, .surround_on, .surround_stereo,
      .surround_mono, .loop_on, .surround_level, .left_atten_db,
      .right_atten_db, .bass_gain_db, .treble_gain_db, .surround_gain_db
   );

   bus_controller_model i_bus_controller_model (
      .sys_clk, .sda_wire, .scl_line, .sda_line
   );

   // ***********************************************
   // Transfer tasks and verdict
   // ***********************************************
   task automatic put(input logic [7:0] b, input logic exp);
      logic ack;
      i_bus_controller_model.send_byte(b, ack);
      `CHECK(ack, exp)
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] idx,
                     input logic [7:0] d [4], input int n, input logic exp);
      i_bus_controller_model.start_cond();
      put(a, exp);
      put(idx, exp);
      for (int i = 0; i < n; i++) begin
         put(d[i], exp);
      end
      i_bus_controller_model.stop_cond();
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog against a hung sequence
   initial begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end

   // ***********************************************
   // Test sequence
   // ***********************************************
   initial begin
      sys_rst = 1'b1;
      chip_strap = 1'b0;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHECK(sda_oe, 1'b0)
      `CHECK(left_atten_db, 7'h7F)
      `CHECK(surround_gain_db, 4'h3)
      // Auto-increment bursts across the map, indexes 0..3 then 4..5
      wr(8'h80, 8'h00, '{8'hFF, 8'h1B, 8'hA5, 8'hA0}, 4, 1'b1);
      wr(8'h80, 8'h04, '{8'h9A, 8'hD5, 8'h00, 8'h00}, 2, 1'b1);
      `CHECK(left_volume, 8'hFF)
      `CHECK(right_volume, 8'h1B)
      `CHECK(left_atten_db, 7'h00)
      `CHECK(right_atten_db, 7'h54)
      `CHECK(enhancer_levels, 8'hA5)
      `CHECK(enhancer_process, 4'hA)
      `CHECK(enhancer_contour, 4'h5)
      `CHECK({enhancer_on, bass_level}, 8'hA0)
      `CHECK({mute_on, treble_level}, 8'h9A)
      `CHECK(treble_gain_db, -5'sd2)
      `CHECK({agc_on, surround_on, surround_stereo}, 3'b110)
      `CHECK({surround_mono, loop_on}, 2'b10)
      `CHECK(surround_level, 3'h5)
      `CHECK(surround_gain_db, 4'h8)
      // Data after data is not an index, no wrap past the top
      wr(8'h80, 8'h03, '{8'h77, 8'h01, 8'h22, 8'h33}, 4, 1'b1);
      `CHECK(enhancer_enable_bass, 8'h77)
      `CHECK(mute_treble, 8'h01)
      `CHECK(gain_ctrl_surround, 8'h22)
      `CHECK(left_volume, 8'hFF)
      // Wrong address and read direction are not answered
      wr(8'h82, 8'h00, '{8'h55, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
      wr(8'h81, 8'h00, '{8'h55, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
      `CHECK(left_volume, 8'hFF)
      chip_strap <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(8'h80, 8'h00, '{8'h44, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
      wr(8'h82, 8'h00, '{8'h55, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      `CHECK(left_volume, 8'h55)
      chip_strap <= 1'b0;
      repeat (4) @(posedge sys_clk);
      // Start in mid-byte aborts, then a fresh write lands
      i_bus_controller_model.start_cond();
      put(8'h80, 1'b1);
      put(8'h01, 1'b1);
      i_bus_controller_model.send_bits(8'h3C, 5);
      i_bus_controller_model.start_cond();
      `CHECK(right_volume, 8'h1B)
      put(8'h80, 1'b1);
      put(8'h01, 1'b1);
      put(8'h66, 1'b1);
      i_bus_controller_model.stop_cond();
      `CHECK(right_volume, 8'h66)
      // Volume codes through the attenuation table
      for (int i = 0; i < 8; i++) begin
         wr(8'h80, 8'h01, '{vc[i], 8'h00, 8'h00, 8'h00}, 1, 1'b1);
         `CHECK(right_atten_db, va[i])
      end
      // Bass codes through the tone table
      for (int i = 0; i < 4; i++) begin
         wr(8'h80, 8'h03, '{tc[i], 8'h00, 8'h00, 8'h00}, 1, 1'b1);
         `CHECK(bass_gain_db, tg[i])
      end
      // Every mode bit and surround level, muted meanwhile
      wr(8'h80, 8'h04, '{8'h80, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wr(8'h80, 8'h05, '{{5'(1 << (i % 5)), 3'(i)}, 8'h00, 8'h00, 8'h00},
            1, 1'b1);
         `CHECK({agc_on, surround_on, surround_stereo, surround_mono, loop_on}, 5'(1 << (i % 5)))
         `CHECK(surround_gain_db, 4'(3 + i))
      end
      give_verdict();
   end
endmodule
